// ---- src/pmc_edge.sv ----
module pmc_edge #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  logic [W-1:0] prev_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prev_q <= '0;
    end else begin
      prev_q <= i_level;
    end
  end

  assign o_rise = i_level & ~prev_q;
  assign o_fall = ~i_level & prev_q;

endmodule

// ---- src/pmc_pkg.sv ----
package pmc_pkg;

  // clock and reset timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_HOLD_NS   = 1000;
  localparam int unsigned RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W     = 8;

  // register port
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_MASK      = 8'h08;
  localparam logic [7:0]  OFS_STATE     = 8'h0c;
  localparam logic [7:0]  OFS_BKP_BASE  = 8'h10;
  localparam logic [7:0]  OFS_BKP_END   = 8'h38;

  // backup registers and wake lines
  localparam int unsigned BKP_NUM       = 10;
  localparam int unsigned BKP_W         = 16;
  localparam int unsigned BKP_IDX_W     = 4;
  localparam int unsigned LINE_NUM      = 16;

  // control register fields
  localparam int unsigned CTRL_W        = 7;
  localparam int unsigned CTRL_THR_EN   = 0;
  localparam int unsigned CTRL_THR_RISE = 1;
  localparam int unsigned CTRL_THR_FALL = 2;
  localparam int unsigned CTRL_STOP_LP  = 3;
  localparam int unsigned CTRL_DEEP     = 4;
  localparam int unsigned CTRL_STANDBY  = 5;
  localparam int unsigned CTRL_CLK_EXT  = 6;
  localparam logic [6:0]  CTRL_RST      = 7'h00;

  // status and mask fields
  localparam int unsigned ST_W          = 3;
  localparam int unsigned ST_THR        = 0;
  localparam int unsigned ST_SBY        = 1;
  localparam int unsigned ST_STOP       = 2;
  localparam logic [2:0]  ST_RST        = 3'h0;
  localparam logic [2:0]  MASK_RST      = 3'h0;

  typedef enum logic [1:0] {
    PMC_REG_MAIN = 2'h0,
    PMC_REG_LP   = 2'h1,
    PMC_REG_OFF  = 2'h2
  } pmc_reg_mode_t;

  typedef enum logic [4:0] {
    PMC_S_RESET   = 5'h01,
    PMC_S_RUN     = 5'h02,
    PMC_S_SLEEP   = 5'h04,
    PMC_S_STOP    = 5'h08,
    PMC_S_STANDBY = 5'h10
  } pmc_state_t;

endpackage

// ---- src/pmc_top.sv ----
// Overview of operation
// - hold core reset while supply is low
// - enabled threshold detector raises selected edge interrupts
// - regulator main, low power, or off
// - regulator on after reset, off in standby
// - stop gates core clocks and fast oscillators
// - stop regulator mode chosen by software beforehand
// - any external line event leaves stop
// - standby powers off core and fast oscillators
// - standby exits on pin, watchdog, wake, alarm
// - rtc and watchdog clocks always keep running
// - ten 16-bit backup registers survive standby
// - after reset the fast rc drives cpu
module pmc_top (
  input  wire logic                          i_clk,
  input  wire logic                          i_srst,
  input  wire logic [pmc_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [pmc_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [pmc_pkg::DATA_W-1:0]    o_rdata,
  input  wire logic                          i_supply_low,
  input  wire logic                          i_thr_below,
  input  wire logic                          i_sleep_req,
  input  wire logic                          i_periph_irq,
  input  wire logic [pmc_pkg::LINE_NUM-1:0]  i_ext_lines,
  input  wire logic                          i_rtc_alarm,
  input  wire logic                          i_usb_wake,
  input  wire logic                          i_reset_pin_n,
  input  wire logic                          i_wdog_rst,
  input  wire logic                          i_wake_pin,
  output logic                               o_core_rst,
  output logic                               o_cpu_clk_en,
  output logic                               o_core_clk_en,
  output logic                               o_pll_en,
  output logic                               o_fast_rc_en,
  output logic                               o_ext_osc_en,
  output logic                               o_clk_sel_ext,
  output logic                               o_reg_en,
  output pmc_pkg::pmc_reg_mode_t             o_reg_mode,
  output logic                               o_lsclk_en,
  output logic                               o_irq
);

  pmc_pkg::pmc_state_t                state_q;
  pmc_pkg::pmc_state_t                state_d;
  logic [pmc_pkg::RST_CNT_W-1:0]      rst_cnt_q;
  logic [pmc_pkg::RST_CNT_W-1:0]      rst_cnt_d;
  logic [pmc_pkg::CTRL_W-1:0]         ctrl_q;
  logic [pmc_pkg::CTRL_W-1:0]         ctrl_d;
  logic [pmc_pkg::ST_W-1:0]           status_q;
  logic [pmc_pkg::ST_W-1:0]           status_d;
  logic [pmc_pkg::ST_W-1:0]           mask_q;
  logic [pmc_pkg::ST_W-1:0]           mask_d;
  logic [pmc_pkg::BKP_W-1:0]          bkp_q [pmc_pkg::BKP_NUM];
  logic [pmc_pkg::DATA_W-1:0]         rdata_q;
  logic [pmc_pkg::DATA_W-1:0]         rdata_d;

  localparam logic [pmc_pkg::RST_CNT_W-1:0] RST_LOAD =
    pmc_pkg::RST_CNT_W'(pmc_pkg::RST_HOLD_CYC - 1);

  // state decode
  wire st_reset   = (state_q == pmc_pkg::PMC_S_RESET);
  wire st_run     = (state_q == pmc_pkg::PMC_S_RUN);
  wire st_sleep   = (state_q == pmc_pkg::PMC_S_SLEEP);
  wire st_stop    = (state_q == pmc_pkg::PMC_S_STOP);
  wire st_standby = (state_q == pmc_pkg::PMC_S_STANDBY);
  // registers are reachable only while the core is powered and clocked
  wire bus_live   = st_run | st_sleep;

  // edge detection on threshold detector and wake pin
  logic thr_rise;
  logic thr_fall;
  logic wake_rise;

  pmc_edge #(
    .W (1)
  ) u_thr_edge (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_level (i_thr_below),
    .o_rise  (thr_rise),
    .o_fall  (thr_fall)
  );

  pmc_edge #(
    .W (1)
  ) u_wake_edge (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_level (i_wake_pin),
    .o_rise  (wake_rise),
    .o_fall  ()
  );

  // below-edge is a falling supply, above-edge a rising one
  wire thr_en    = ctrl_q[pmc_pkg::CTRL_THR_EN];
  wire thr_event = thr_en & ((ctrl_q[pmc_pkg::CTRL_THR_FALL] & thr_rise) |
                             (ctrl_q[pmc_pkg::CTRL_THR_RISE] & thr_fall));

  // wake sources per mode
  wire line_any   = |i_ext_lines;
  wire sleep_wake = i_periph_irq | line_any;
  wire stop_wake  = line_any | thr_event | i_rtc_alarm | i_usb_wake;
  wire sby_wake   = ~i_reset_pin_n | i_wdog_rst | wake_rise | i_rtc_alarm;

  // register decode
  wire wr_ok     = i_wr & bus_live;
  wire rd_ok     = i_rd & bus_live;
  wire hit_ctrl  = (i_addr == pmc_pkg::OFS_CTRL);
  wire hit_stat  = (i_addr == pmc_pkg::OFS_STATUS);
  wire hit_mask  = (i_addr == pmc_pkg::OFS_MASK);
  wire hit_state = (i_addr == pmc_pkg::OFS_STATE);
  wire hit_bkp   = (i_addr >= pmc_pkg::OFS_BKP_BASE) &&
                   (i_addr < pmc_pkg::OFS_BKP_END) && (i_addr[1:0] == 2'h0);
  wire [pmc_pkg::ADDR_W-1:0]    bkp_off = i_addr - pmc_pkg::OFS_BKP_BASE;
  wire [pmc_pkg::BKP_IDX_W-1:0] bkp_idx = bkp_off[5:2];
  wire bkp_wr    = wr_ok & hit_bkp;

  // core reset sequence and mode control
  always_comb begin
    state_d   = state_q;
    rst_cnt_d = rst_cnt_q;
    case (state_q)
      pmc_pkg::PMC_S_RESET: begin
        if (rst_cnt_q == '0) begin
          state_d = pmc_pkg::PMC_S_RUN;
        end else begin
          rst_cnt_d = rst_cnt_q - 1'b1;
        end
      end
      pmc_pkg::PMC_S_RUN: begin
        if (i_sleep_req) begin
          if (!ctrl_q[pmc_pkg::CTRL_DEEP]) begin
            state_d = pmc_pkg::PMC_S_SLEEP;
          end else if (ctrl_q[pmc_pkg::CTRL_STANDBY]) begin
            state_d = pmc_pkg::PMC_S_STANDBY;
          end else begin
            state_d = pmc_pkg::PMC_S_STOP;
          end
        end
      end
      pmc_pkg::PMC_S_SLEEP: begin
        if (sleep_wake) begin
          state_d = pmc_pkg::PMC_S_RUN;
        end
      end
      pmc_pkg::PMC_S_STOP: begin
        if (stop_wake) begin
          state_d = pmc_pkg::PMC_S_RUN;
        end
      end
      pmc_pkg::PMC_S_STANDBY: begin
        if (sby_wake) begin
          state_d   = pmc_pkg::PMC_S_RESET;
          rst_cnt_d = RST_LOAD;
        end
      end
      default: begin
        state_d   = pmc_pkg::PMC_S_RESET;
        rst_cnt_d = RST_LOAD;
      end
    endcase
    // a low supply overrides every mode and restarts the hold
    if (i_supply_low) begin
      state_d   = pmc_pkg::PMC_S_RESET;
      rst_cnt_d = RST_LOAD;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q   <= pmc_pkg::PMC_S_RESET;
      rst_cnt_q <= RST_LOAD;
    end else begin
      state_q   <= state_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end

  // control and mask are core registers: lost across reset and standby
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    if (st_reset || st_standby) begin
      ctrl_d = pmc_pkg::CTRL_RST;
      mask_d = pmc_pkg::MASK_RST;
    end else if (wr_ok && hit_ctrl) begin
      ctrl_d = i_wdata[pmc_pkg::CTRL_W-1:0];
    end else if (wr_ok && hit_mask) begin
      mask_d = i_wdata[pmc_pkg::ST_W-1:0];
    end
  end

  // status sits in the standby circuitry; a set wins over a same-cycle clear
  wire [pmc_pkg::ST_W-1:0] st_clr = (wr_ok && hit_stat) ? i_wdata[pmc_pkg::ST_W-1:0] : '0;
  wire [pmc_pkg::ST_W-1:0] st_set;
  assign st_set[pmc_pkg::ST_THR]  = thr_event;
  assign st_set[pmc_pkg::ST_SBY]  = st_standby & sby_wake & ~i_supply_low;
  assign st_set[pmc_pkg::ST_STOP] = st_stop & stop_wake & ~i_supply_low;

  always_comb begin
    status_d = (status_q & ~st_clr) | st_set;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_q   <= pmc_pkg::CTRL_RST;
      mask_q   <= pmc_pkg::MASK_RST;
      status_q <= pmc_pkg::ST_RST;
    end else begin
      ctrl_q   <= ctrl_d;
      mask_q   <= mask_d;
      status_q <= status_d;
    end
  end

  // battery-backed store: only the backup-domain reset clears it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i < pmc_pkg::BKP_NUM; i++) begin
        bkp_q[i] <= '0;
      end
    end else if (bkp_wr) begin
      bkp_q[bkp_idx] <= i_wdata[pmc_pkg::BKP_W-1:0];
    end
  end

  // read path, data valid in the cycle after the strobe
  wire [pmc_pkg::DATA_W-1:0] rd_ctrl  = {{(pmc_pkg::DATA_W-pmc_pkg::CTRL_W){1'b0}}, ctrl_q};
  wire [pmc_pkg::DATA_W-1:0] rd_stat  = {{(pmc_pkg::DATA_W-pmc_pkg::ST_W){1'b0}}, status_q};
  wire [pmc_pkg::DATA_W-1:0] rd_mask  = {{(pmc_pkg::DATA_W-pmc_pkg::ST_W){1'b0}}, mask_q};
  wire [pmc_pkg::DATA_W-1:0] rd_state = {26'h0, i_thr_below, state_q};
  wire [pmc_pkg::DATA_W-1:0] rd_bkp   = {16'h0, bkp_q[bkp_idx]};

  assign rdata_d = !rd_ok    ? '0 :
                   hit_ctrl  ? rd_ctrl :
                   hit_stat  ? rd_stat :
                   hit_mask  ? rd_mask :
                   hit_state ? rd_state :
                   hit_bkp   ? rd_bkp : '0;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs
  wire core_active = ~(st_stop | st_standby);

  assign o_rdata       = rdata_q;
  assign o_core_rst    = st_reset | i_supply_low;
  assign o_cpu_clk_en  = st_run | st_reset;
  assign o_core_clk_en = core_active;
  assign o_fast_rc_en  = core_active;
  assign o_pll_en      = core_active & ctrl_q[pmc_pkg::CTRL_CLK_EXT];
  assign o_ext_osc_en  = core_active & ctrl_q[pmc_pkg::CTRL_CLK_EXT];
  assign o_clk_sel_ext = ctrl_q[pmc_pkg::CTRL_CLK_EXT];
  assign o_reg_en      = ~st_standby;
  assign o_reg_mode    = st_standby ? pmc_pkg::PMC_REG_OFF :
                         (st_stop && ctrl_q[pmc_pkg::CTRL_STOP_LP]) ? pmc_pkg::PMC_REG_LP :
                         pmc_pkg::PMC_REG_MAIN;
  // low-speed clocks are never gated by this block
  assign o_lsclk_en    = 1'b1;
  assign o_irq         = |(status_q & mask_q);

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_sby_exit;
    st_standby && sby_wake && !i_supply_low;
  endsequence

  sequence s_reset_then_flag;
    st_reset && o_core_rst && !o_clk_sel_ext ##0 status_q[pmc_pkg::ST_SBY];
  endsequence

  supply_hold_a: assert property (i_supply_low |=> st_reset && o_core_rst)
    else $error("core not held in reset under low supply");

  thr_fall_irq_a: assert property (
    thr_en && ctrl_q[pmc_pkg::CTRL_THR_FALL] && $rose(i_thr_below)
    |=> status_q[pmc_pkg::ST_THR])
    else $error("supply drop not flagged");

  reg_standby_a: assert property (st_standby |-> !o_reg_en && o_reg_mode == pmc_pkg::PMC_REG_OFF)
    else $error("regulator not off in standby");

  reg_run_a: assert property ($fell(st_reset) |-> o_reg_en && o_reg_mode == pmc_pkg::PMC_REG_MAIN)
    else $error("regulator not on after reset");

  sleep_wake_a: assert property (st_sleep && i_periph_irq && !i_supply_low |=> st_run && o_cpu_clk_en)
    else $error("sleep did not wake on peripheral event");

  stop_clk_a: assert property (st_stop |-> !o_core_clk_en && !o_pll_en && !o_fast_rc_en && !o_ext_osc_en)
    else $error("clocks running in stop");

  stop_reg_a: assert property (
    st_stop |-> o_reg_mode == (ctrl_q[pmc_pkg::CTRL_STOP_LP] ? pmc_pkg::PMC_REG_LP : pmc_pkg::PMC_REG_MAIN))
    else $error("stop regulator mode wrong");

  stop_wake_a: assert property (
    st_stop && line_any && !i_supply_low |=> st_run && status_q[pmc_pkg::ST_STOP] && !o_core_rst)
    else $error("stop did not resume on line event");

  sby_stay_a: assert property (st_standby && !sby_wake && !i_supply_low |=> st_standby)
    else $error("standby left without wake source");

  sby_exit_a: assert property (s_sby_exit |=> s_reset_then_flag)
    else $error("standby exit skipped reset");

  lsclk_low_a: assert property ((st_stop || st_standby) |-> o_lsclk_en)
    else $error("low-speed clock gated in low-power mode");

  bkp_keep_a: assert property (st_standby |=> bkp_q[0] == $past(bkp_q[0]))
    else $error("backup register changed in standby");

  clk_rc_a: assert property (st_reset |=> !o_clk_sel_ext)
    else $error("fast rc not selected after reset");

endmodule

// ---- tb/pmc_top_test.sv ----
module pmc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_supply_low = 1'b0;
  logic        i_thr_below = 1'b0;
  logic        i_sleep_req = 1'b0;
  logic        fire = 1'b0;
  logic [2:0]  kind = 3'h0;
  logic [31:0] o_rdata;
  logic [15:0] lines;
  logic        periph, rtc, usb, wdog, wpin, rpin_n;
  logic        o_core_rst, o_cpu_clk_en, o_core_clk_en, o_pll_en, o_fast_rc_en;
  logic        o_ext_osc_en, o_clk_sel_ext, o_reg_en, o_lsclk_en, o_irq;
  pmc_pkg::pmc_reg_mode_t o_reg_mode;
  int          fail_count = 0;
  int          check_count = 0;
  logic [31:0] d;

  pmc_wake_model pmc_wake_model_i (.i_clk(i_clk), .i_fire(fire), .i_kind(kind),
    .o_periph_irq(periph), .o_lines(lines), .o_rtc_alarm(rtc), .o_usb_wake(usb),
    .o_wdog_rst(wdog), .o_wake_pin(wpin), .o_reset_pin_n(rpin_n));
  pmc_top pmc_top_i (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_low(i_supply_low),
    .i_thr_below(i_thr_below), .i_sleep_req(i_sleep_req), .i_periph_irq(periph),
    .i_ext_lines(lines), .i_rtc_alarm(rtc), .i_usb_wake(usb), .i_reset_pin_n(rpin_n),
    .i_wdog_rst(wdog), .i_wake_pin(wpin), .o_core_rst(o_core_rst),
    .o_cpu_clk_en(o_cpu_clk_en), .o_core_clk_en(o_core_clk_en), .o_pll_en(o_pll_en),
    .o_fast_rc_en(o_fast_rc_en), .o_ext_osc_en(o_ext_osc_en),
    .o_clk_sel_ext(o_clk_sel_ext), .o_reg_en(o_reg_en), .o_reg_mode(o_reg_mode),
    .o_lsclk_en(o_lsclk_en), .o_irq(o_irq));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic test_done();
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic ck(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  // one event from the far side; the mode changes on the edge after it arrives
  task automatic ev(logic [2:0] k);
    @(posedge i_clk);
    fire <= 1'b1;
    kind <= k;
    @(posedge i_clk);
    fire <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask

  task automatic req();
    @(posedge i_clk);
    i_sleep_req <= 1'b1;
    @(posedge i_clk);
    i_sleep_req <= 1'b0;
    #1;
  endtask

  // bounded wait for the reset sequence to release the core
  task automatic wait_run();
    int n;
    n = 0;
    while (o_core_rst !== 1'b0) begin
      @(posedge i_clk);
      #1 n++;
      if (n > 300) begin
        $display("[ERR] core reset release expected 0 seen %b", o_core_rst);
        fail_count++;
        test_done();
      end
    end
  endtask

  task automatic t_reset();
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (6) @(posedge i_clk);
    #1 ck("core_rst", 1, o_core_rst);
    ck("reg_en", 1, o_reg_en);
    ck("reg_mode", pmc_pkg::PMC_REG_MAIN, o_reg_mode);
    ck("clk_sel_ext", 0, o_clk_sel_ext);
    ck("fast_rc_en", 1, o_fast_rc_en);
    @(posedge i_clk);
    i_srst <= 1'b0;
    wait_run();
    rd(pmc_pkg::OFS_STATE);
    ck("state", 32'h02, d & 32'h1f);
  endtask

  task automatic t_supply();
    @(posedge i_clk);
    i_supply_low <= 1'b1;
    #1 ck("core_rst low supply", 1, o_core_rst);
    @(posedge i_clk);
    i_supply_low <= 1'b0;
    #1 ck("core_rst held", 1, o_core_rst);
    wait_run();
  endtask

  task automatic t_sleep();
    for (int k = 0; k < 2; k++) begin
      wr(pmc_pkg::OFS_CTRL, 32'h0);
      req();
      ck("sleep cpu_clk_en", 0, o_cpu_clk_en);
      ck("sleep core_clk_en", 1, o_core_clk_en);
      ev(3'(k));
      ck("sleep exit cpu_clk_en", 1, o_cpu_clk_en);
    end
  endtask

  task automatic t_stop();
    for (int i = 0; i < 3; i++) begin
      wr(pmc_pkg::OFS_CTRL, 32'h50 | (32'(i & 1) << 3));
      req();
      ck("stop core_clk_en", 0, o_core_clk_en);
      ck("stop pll_en", 0, o_pll_en);
      ck("stop ext_osc_en", 0, o_ext_osc_en);
      ck("stop fast_rc_en", 0, o_fast_rc_en);
      ck("stop reg_mode", (i & 1) ? 1 : 0, o_reg_mode);
      ck("stop lsclk_en", 1, o_lsclk_en);
      ev(3'(i + 1));
      ck("stop exit core_clk_en", 1, o_core_clk_en);
      ck("stop exit clk_sel_ext", 1, o_clk_sel_ext);
      ck("stop exit pll_en", 1, o_pll_en);
      ck("stop exit reg_mode", pmc_pkg::PMC_REG_MAIN, o_reg_mode);
      rd(pmc_pkg::OFS_STATUS);
      ck("stop exit status", 32'h4, d & 32'h4);
      wr(pmc_pkg::OFS_STATUS, 32'h4);
    end
  endtask

  task automatic t_standby();
    logic [2:0] src [4] = '{3'h6, 3'h4, 3'h5, 3'h2};
    for (int i = 0; i < 10; i++) wr(8'h10 + 8'(4 * i), 32'hffff_a500 + 32'(i));
    for (int i = 0; i < 4; i++) begin
      wr(pmc_pkg::OFS_CTRL, 32'h70);
      req();
      ck("standby reg_en", 0, o_reg_en);
      ck("standby reg_mode", pmc_pkg::PMC_REG_OFF, o_reg_mode);
      ck("standby core_clk_en", 0, o_core_clk_en);
      ck("standby pll_en", 0, o_pll_en);
      ck("standby lsclk_en", 1, o_lsclk_en);
      ev(3'h0);
      ck("standby ignores irq", 0, o_reg_en);
      ev(src[i]);
      ck("standby exit core_rst", 1, o_core_rst);
      wait_run();
      ck("standby exit clk_sel_ext", 0, o_clk_sel_ext);
      rd(pmc_pkg::OFS_STATUS);
      ck("standby exit status", 32'h2, d & 32'h2);
      wr(pmc_pkg::OFS_STATUS, 32'h2);
    end
    for (int i = 0; i < 10; i++) begin
      rd(8'h10 + 8'(4 * i));
      ck("backup reg", 32'ha500 + 32'(i), d);
    end
    wr(8'h40, 32'h1234);
    rd(8'h40);
    ck("unmapped read", 0, d);
  endtask

  task automatic t_thr();
    wr(pmc_pkg::OFS_MASK, 32'h1);
    wr(pmc_pkg::OFS_CTRL, 32'h5);
    @(posedge i_clk);
    i_thr_below <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 ck("irq on fall below", 1, o_irq);
    wr(pmc_pkg::OFS_STATUS, 32'h1);
    #1 ck("irq cleared", 0, o_irq);
    wr(pmc_pkg::OFS_CTRL, 32'h3);
    @(posedge i_clk);
    i_thr_below <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 ck("irq on rise above", 1, o_irq);
    wr(pmc_pkg::OFS_MASK, 32'h0);
    #1 ck("irq masked", 0, o_irq);
    wr(pmc_pkg::OFS_STATUS, 32'h1);
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    wait_run();
    t_reset();
    t_supply();
    t_sleep();
    t_stop();
    t_standby();
    t_thr();
    test_done();
  end
endmodule

// ---- tb/pmc_wake_model.sv ----
module pmc_wake_model (
  input  wire logic        i_clk,
  input  wire logic        i_fire,
  input  wire logic [2:0]  i_kind,
  output logic             o_periph_irq,
  output logic [15:0]      o_lines,
  output logic             o_rtc_alarm,
  output logic             o_usb_wake,
  output logic             o_wdog_rst,
  output logic             o_wake_pin,
  output logic             o_reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // every source is a one-cycle event; the wake pin pulse gives one rising edge
  always @(posedge i_clk) begin
    o_periph_irq  <= i_fire && i_kind == 3'h0;
    o_lines       <= (i_fire && i_kind == 3'h1) ? 16'h8000 : 16'h0000;
    o_rtc_alarm   <= i_fire && i_kind == 3'h2;
    o_usb_wake    <= i_fire && i_kind == 3'h3;
    o_wdog_rst    <= i_fire && i_kind == 3'h4;
    o_wake_pin    <= i_fire && i_kind == 3'h5;
    o_reset_pin_n <= !(i_fire && i_kind == 3'h6);
  end
  initial begin
    o_periph_irq  = 1'b0;
    o_lines       = 16'h0000;
    o_rtc_alarm   = 1'b0;
    o_usb_wake    = 1'b0;
    o_wdog_rst    = 1'b0;
    o_wake_pin    = 1'b0;
    o_reset_pin_n = 1'b1;
  end
endmodule
